// ---- src/rtc_port_pkg.sv ----
// Shared constants and pin bundles for the real-time-clock host port
package rtc_port_pkg;

	// ----------------------------------------------------------------
	// Widths and levels
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 4;
	localparam logic        MODE_68       = 1'b1;
	localparam logic        MODE_80       = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ       = 40;
	localparam int          PULSE_NS      = 1000;
	localparam int          PULSE_CYCLES  = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int          PULSE_CNT_W   = $clog2(PULSE_CYCLES + 1);

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST    = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST    = 4'h0;
	localparam logic              CS_LOW_RST  = 1'b1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              bus_mode;
		logic              chip_select_low_active_n;
		logic              chip_select_high_active;
		logic              ale;
		logic              wr_rw;
		logic              rd_e;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_pins_t;

	localparam int PINS_W = $bits(bus_pins_t);

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		PER_IDLE  = 2'b00,
		PER_PULSE = 2'b01,
		PER_HOLD  = 2'b10
	} per_state_t;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// Levels
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_rst_val,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// i_rst_val is a constant at every instance
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async ^ i_rst_val;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r ^ i_rst_val;

endmodule

// ---- src/rtc_host_bus_interface.sv ----
// Parallel host port of the real-time clock: select gating, address latch, data drive
//
// Summary of operation
// - 80-style: drive data only when selected, read strobe low, write strobe high.
// - 68-style: drive data only when selected, R/W high and E high.
// - Host presents four-bit address; device decodes it with the address latch.
// - Latch enable high passes address and low-active select through.
// - Latch enable falling holds captured address and low-active select.
// - High-active select bypasses the latch and acts directly always.
// - Latch, write and read inputs accepted only while the high-active select is active.
// - Otherwise behave as latch closed and strobes idle; nothing happens.
// - Periodic output gives a pulse or interrupt on each selected carry.
// - Periodic output works regardless of both chip selects.
// - Bus-style input high selects 68-style, low selects 80-style.
// - Periodic output enabled when mask bit is 0, disabled at 1.
`timescale 1ns/10ps
module rtc_host_bus_interface (
	// Clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_reset,
	// Host pins
	input  wire logic                          i_bus_mode,
	input  wire logic                          i_chip_select_low_active_n,
	input  wire logic                          i_chip_select_high_active,
	input  wire logic                          i_ale,
	input  wire logic                          i_wr_rw,
	input  wire logic                          i_rd_e,
	input  wire logic [rtc_port_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [rtc_port_pkg::DATA_W-1:0] i_data,
	output logic      [rtc_port_pkg::DATA_W-1:0] o_data,
	output logic                               o_data_oe,
	// Register side
	output rtc_port_pkg::reg_req_t             o_reg_req,
	input  wire logic [rtc_port_pkg::DATA_W-1:0] i_reg_rdata,
	// Periodic event
	input  wire logic                          i_carry,
	input  wire logic                          i_carry_event_mask,
	input  wire logic                          i_irq_mode,
	input  wire logic                          i_irq_clear,
	output logic                               o_periodic_oe
);
	import rtc_port_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	bus_pins_t pins_raw;
	bus_pins_t pins_rst;
	bus_pins_t pins_s;
	logic [PINS_W-1:0] pins_s_vec;

	always_comb begin
		pins_raw = '{bus_mode: i_bus_mode,
			chip_select_low_active_n: i_chip_select_low_active_n,
			chip_select_high_active: i_chip_select_high_active,
			ale: i_ale, wr_rw: i_wr_rw, rd_e: i_rd_e, addr: i_addr, data: i_data};
		pins_rst = '0;
		pins_rst.chip_select_low_active_n = CS_LOW_RST;
		pins_s = bus_pins_t'(pins_s_vec);
	end

	pin_sync #(.W(PINS_W)) u_sync (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_async   (pins_raw),
		.i_rst_val (pins_rst),
		.o_sync    (pins_s_vec)
	);

	// ----------------------------------------------------------------
	// Select gating and address latch
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] addr_lat_r,  addr_lat_nxt;
	logic              cs0_lat_r,   cs0_lat_nxt;
	logic              latch_open;
	logic [ADDR_W-1:0] addr_eff;
	logic              cs0_eff;
	logic              sel;
	logic              is_68;
	logic              rd_act;
	logic              wr_act;

	always_comb begin
		is_68 = (pins_s.bus_mode == MODE_68);
		// High-active select gates the latch directly, never latched
		latch_open = pins_s.ale & pins_s.chip_select_high_active;
		addr_eff = latch_open ? pins_s.addr : addr_lat_r;
		cs0_eff  = latch_open ? pins_s.chip_select_low_active_n : cs0_lat_r;
		sel = ~cs0_eff & pins_s.chip_select_high_active;
		addr_lat_nxt = latch_open ? pins_s.addr : addr_lat_r;
		cs0_lat_nxt  = latch_open ? pins_s.chip_select_low_active_n : cs0_lat_r;
		// Deselected: strobes read as idle
		if (is_68) begin
			rd_act = sel & pins_s.rd_e & pins_s.wr_rw;
			wr_act = sel & pins_s.rd_e & ~pins_s.wr_rw;
		end else begin
			rd_act = sel & ~pins_s.rd_e & pins_s.wr_rw;
			wr_act = sel & ~pins_s.wr_rw;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			addr_lat_r <= ADDR_RST;
			cs0_lat_r  <= CS_LOW_RST;
		end else begin
			addr_lat_r <= addr_lat_nxt;
			cs0_lat_r  <= cs0_lat_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Access sequencing
	// ----------------------------------------------------------------
	logic              rd_act_r,  rd_act_nxt;
	logic              wr_act_r,  wr_act_nxt;
	logic              oe_r,      oe_nxt;
	logic [DATA_W-1:0] rdata_r,   rdata_nxt;
	reg_req_t          req_r,     req_nxt;

	always_comb begin
		rd_act_nxt = rd_act;
		wr_act_nxt = wr_act;
		oe_nxt     = rd_act;
		rdata_nxt  = rd_act ? i_reg_rdata : rdata_r;
		req_nxt    = req_r;
		req_nxt.wr = 1'b0;
		req_nxt.rd = rd_act & ~rd_act_r;
		if (rd_act & ~rd_act_r) begin
			req_nxt.addr = addr_eff;
		end
		if (wr_act) begin
			req_nxt.addr  = addr_eff;
			req_nxt.wdata = pins_s.data;
		end
		// Commit on the trailing edge only while still selected
		if (wr_act_r & ~wr_act & sel) begin
			req_nxt.wr = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_act_r <= 1'b0;
			wr_act_r <= 1'b0;
			oe_r     <= 1'b0;
			rdata_r  <= DATA_RST;
			req_r    <= '0;
		end else begin
			rd_act_r <= rd_act_nxt;
			wr_act_r <= wr_act_nxt;
			oe_r     <= oe_nxt;
			rdata_r  <= rdata_nxt;
			req_r    <= req_nxt;
		end
	end

	assign o_data    = rdata_r;
	assign o_data_oe = oe_r;
	assign o_reg_req = req_r;

	// ----------------------------------------------------------------
	// Periodic output
	// ----------------------------------------------------------------
	per_state_t             per_r,   per_nxt;
	logic [PULSE_CNT_W-1:0] cnt_r,   cnt_nxt;

	// No select term appears here on purpose
	always_comb begin
		per_nxt = per_r;
		cnt_nxt = cnt_r;
		case (per_r)
			PER_IDLE: begin
				if (i_carry & ~i_carry_event_mask) begin
					per_nxt = i_irq_mode ? PER_HOLD : PER_PULSE;
					cnt_nxt = PULSE_CNT_W'(PULSE_CYCLES - 1);
				end
			end
			PER_PULSE: begin
				if (cnt_r == '0) begin
					per_nxt = PER_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			PER_HOLD: begin
				// A new carry in the clearing cycle keeps the request
				if (i_irq_clear & ~(i_carry & ~i_carry_event_mask)) begin
					per_nxt = PER_IDLE;
				end
			end
			default: begin
				per_nxt = PER_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			per_r <= PER_IDLE;
			cnt_r <= '0;
		end else begin
			per_r <= per_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign o_periodic_oe = (per_r != PER_IDLE);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	read80_drive_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!is_68 && sel && !pins_s.rd_e && pins_s.wr_rw |=> o_data_oe)
		else $error("80-style read did not drive data");

	read68_drive_a: assert property (@(posedge i_clk) disable iff (i_reset)
		is_68 && sel && pins_s.rd_e && pins_s.wr_rw |=> o_data_oe)
		else $error("68-style read did not drive data");

	desel_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!sel |=> !o_data_oe && !o_reg_req.wr && !o_reg_req.rd)
		else $error("deselected port drove or accessed");

	latch_pass_a: assert property (@(posedge i_clk) disable iff (i_reset)
		latch_open |=> addr_lat_r == $past(pins_s.addr))
		else $error("open latch did not follow address");

	latch_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!latch_open ##1 !latch_open |-> $stable(addr_lat_r) && $stable(cs0_lat_r))
		else $error("closed latch changed");

	write_commit_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(wr_act) && sel |=> o_reg_req.wr && o_reg_req.wdata == $past(pins_s.data, 2))
		else $error("write not committed at strobe end");

	pulse_width_a: assert property (@(posedge i_clk) disable iff (i_reset)
		per_r == PER_IDLE && i_carry && !i_carry_event_mask && !i_irq_mode
		|=> o_periodic_oe [*8])
		else $error("periodic pulse too short");

	mask_block_a: assert property (@(posedge i_clk) disable iff (i_reset)
		per_r == PER_IDLE && i_carry_event_mask |=> !o_periodic_oe)
		else $error("masked carry produced output");

	irq_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		per_r == PER_IDLE && i_carry && !i_carry_event_mask && i_irq_mode && !sel
		##1 !i_irq_clear [*3] |=> o_periodic_oe)
		else $error("interrupt request lost while deselected");

endmodule

// ---- verification/host_model.sv ----
// Behavioural microcomputer driving the host port pins
`timescale 1ns/10ps
module host_model
	import rtc_port_pkg::*;
(
	// Clock
	input  wire logic i_clk,
	// Host pins
	output bus_pins_t o_pins
);
	initial begin
		o_pins = '0;
		o_pins.chip_select_low_active_n = 1'b1;
		o_pins.chip_select_high_active = 1'b1;
		o_pins.ale = 1'b1;
		o_pins.wr_rw = 1'b1;
		o_pins.rd_e = 1'b1;
	end

	task automatic set_mode(input logic m);
		@(posedge i_clk);
		o_pins.bus_mode <= m;
		o_pins.rd_e <= ~m;
		repeat (3) @(posedge i_clk);
	endtask

	// Sel is {low-active select pin, high-active select pin}
	task automatic start(input logic wr, input logic [3:0] a, input logic [3:0] d,
			input logic lat, input logic [1:0] sel);
		@(posedge i_clk);
		o_pins.addr <= a;
		o_pins.chip_select_low_active_n <= sel[1];
		o_pins.chip_select_high_active <= sel[0];
		o_pins.wr_rw <= o_pins.bus_mode ? ~wr : 1'b1;
		if (lat) begin
			repeat (3) @(posedge i_clk);
			o_pins.ale <= 1'b0;
			@(posedge i_clk);
			// Multiplexed bus moves on; the port must keep the latched values
			o_pins.addr <= ~a;
			o_pins.chip_select_low_active_n <= 1'b1;
		end
		@(posedge i_clk);
		o_pins.data <= wr ? d : ~o_pins.data;
		if (o_pins.bus_mode) o_pins.rd_e <= 1'b1;
		else if (wr) o_pins.wr_rw <= 1'b0;
		else o_pins.rd_e <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask

	task automatic stop();
		@(posedge i_clk);
		o_pins.rd_e <= ~o_pins.bus_mode;
		if (!o_pins.bus_mode) o_pins.wr_rw <= 1'b1;
		@(posedge i_clk);
		// Released data lines show an inverted value; strobes, latch enable and low-active select go back to idle; high-active select is driven high (active)
		o_pins.wr_rw <= 1'b1;
		o_pins.data <= ~o_pins.data;
		o_pins.ale <= 1'b1;
		o_pins.chip_select_low_active_n <= 1'b1;
		o_pins.chip_select_high_active <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask
endmodule

// ---- verification/rtc_host_bus_interface_bench.sv ----
// Self-checking bench for the real-time-clock host port
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rtc_host_bus_interface_bench;
	import rtc_port_pkg::*;
	logic              i_clk;
	logic              i_reset;
	bus_pins_t         pins;
	logic [DATA_W-1:0] o_data;
	logic [DATA_W-1:0] i_reg_rdata;
	logic              o_data_oe;
	logic              o_periodic_oe;
	reg_req_t          o_reg_req;
	logic              i_carry;
	logic              i_carry_event_mask;
	logic              i_irq_mode;
	logic              i_irq_clear;
	logic [3:0]        rf [16] = '{default: 4'h0};
	int                mdl [16] = '{default: 0};
	int                n_fail = 0;
	int                n_checks = 0;
	int                wr_cnt = 0;
	int                oe_cnt = 0;
	int                rd_cnt = 0;
	logic [7:0]        seed = 8'h3d;
	logic [7:0]        wa;

	host_model host (.i_clk(i_clk), .o_pins(pins));

	rtc_host_bus_interface uut (
		.i_clk(i_clk), .i_reset(i_reset),
		.i_bus_mode(pins.bus_mode),
		.i_chip_select_low_active_n(pins.chip_select_low_active_n),
		.i_chip_select_high_active(pins.chip_select_high_active),
		.i_ale(pins.ale), .i_wr_rw(pins.wr_rw), .i_rd_e(pins.rd_e), .i_addr(pins.addr),
		.i_data(o_data_oe ? o_data : pins.data), .o_data(o_data), .o_data_oe(o_data_oe),
		.o_reg_req(o_reg_req), .i_reg_rdata(i_reg_rdata),
		.i_carry(i_carry), .i_carry_event_mask(i_carry_event_mask),
		.i_irq_mode(i_irq_mode), .i_irq_clear(i_irq_clear), .o_periodic_oe(o_periodic_oe)
	);

	// Register block seen behind the port
	assign i_reg_rdata = rf[o_reg_req.addr];
	always @(posedge i_clk) begin
		if (o_reg_req.wr === 1'b1) begin
			rf[o_reg_req.addr] <= o_reg_req.wdata;
			wa <= {o_reg_req.addr, o_reg_req.wdata};
			wr_cnt <= wr_cnt + 1;
		end
		if (o_data_oe === 1'b1) oe_cnt <= oe_cnt + 1;
		if (o_reg_req.rd === 1'b1) rd_cnt <= rd_cnt + 1;
	end

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic end_of_test();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic op(input logic wr, input logic [3:0] a, input logic [3:0] d,
			input logic lat, input logic [1:0] sel);
		int w0;
		int e0;
		int r0;
		logic hit;
		w0 = wr_cnt;
		e0 = oe_cnt;
		r0 = rd_cnt;
		hit = (sel == 2'b01);
		host.start(wr, a, d, lat, sel);
		#1;
		if (!wr) `CHK(o_data_oe, hit)
		if (!wr && hit) `CHK(o_data, 4'(mdl[a]))
		host.stop();
		#1;
		`CHK(o_data_oe, 1'b0)
		`CHK(wr_cnt - w0, (wr && hit) ? 1 : 0)
		if (wr) `CHK(oe_cnt - e0, 0)
		if (wr && hit) `CHK(wa, {a, d})
		`CHK(rd_cnt - r0, (!wr && hit) ? 1 : 0)
		if (hit) `CHK(o_reg_req.addr, a)
		if (wr && hit) mdl[a] = d;
	endtask

	task automatic carry(input logic m, input logic irq, input int exp);
		int k;
		k = 0;
		@(posedge i_clk);
		i_carry_event_mask <= m;
		i_irq_mode <= irq;
		i_carry <= 1'b1;
		@(posedge i_clk);
		i_carry <= 1'b0;
		repeat (60) begin
			#1 k += o_periodic_oe;
			@(posedge i_clk);
		end
		`CHK(k, exp)
		i_irq_clear <= 1'b1;
		@(posedge i_clk);
		i_irq_clear <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 `CHK(o_periodic_oe, 1'b0)
	endtask

	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		i_reset = 1'b1;
		i_carry = 1'b0;
		i_carry_event_mask = 1'b1;
		i_irq_mode = 1'b0;
		i_irq_clear = 1'b0;
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		#1 `CHK({o_data_oe, o_reg_req.wr, o_reg_req.rd, o_periodic_oe}, 4'h0)
		for (int m = 0; m < 2; m++) begin
			host.set_mode(m[0]);
			for (int i = 0; i < 6; i++) begin
				seed = lfsr(seed);
				op(1'b1, seed[3:0], seed[7:4], i[0], 2'b01);
				op(1'b0, seed[3:0], 4'h0, ~i[0], 2'b01);
			end
			op(1'b1, seed[3:0], ~seed[7:4], 1'b0, 2'b11);
			op(1'b1, seed[3:0], ~seed[7:4], 1'b1, 2'b00);
			op(1'b0, seed[3:0], 4'h0, 1'b0, 2'b00);
			op(1'b0, seed[3:0], 4'h0, 1'b1, 2'b01);
			$display("bus test mode %0d done", m);
		end
		carry(1'b0, 1'b0, PULSE_CYCLES);
		carry(1'b1, 1'b0, 0);
		carry(1'b0, 1'b1, 60);
		$display("periodic test done");
		end_of_test();
	end
endmodule
